// [core/gauge_ctl_pkg.sv]
package gauge_ctl_pkg;
  // Command code pair of the control word on the serial link.
  localparam logic [7:0] CODE_CTL_LO = 8'h00;
  localparam logic [7:0] CODE_CTL_HI = 8'h01;
  // Control subcommand codes.
  localparam logic [15:0] SUB_STATUS = 16'h0000;
  localparam logic [15:0] SUB_DEV_TYPE = 16'h0001;
  localparam logic [15:0] SUB_FW_REV = 16'h0002;
  localparam logic [15:0] SUB_HW_REV = 16'h0003;
  localparam logic [15:0] SUB_SUM = 16'h0004;
  localparam logic [15:0] SUB_RESET_DATA = 16'h0005;
  localparam logic [15:0] SUB_RESERVED = 16'h0006;
  localparam logic [15:0] SUB_LAST = 16'h0007;
  localparam logic [15:0] SUB_CHEM = 16'h0008;
  localparam logic [15:0] SUB_DEEP_DOZE = 16'h0010;
  localparam logic [15:0] SUB_SET_HIB = 16'h0011;
  localparam logic [15:0] SUB_CLR_HIB = 16'h0012;
  localparam logic [15:0] SUB_SET_SHDN = 16'h0013;
  localparam logic [15:0] SUB_CLR_SHDN = 16'h0014;
  localparam logic [15:0] SUB_SEAL = 16'h0020;
  localparam logic [15:0] SUB_GAUGE_START = 16'h0021;
  localparam logic [15:0] SUB_CAL_MODE = 16'h0040;
  localparam logic [15:0] SUB_RESET = 16'h0041;
  // Status word field positions.
  localparam int BIT_SE = 15;
  localparam int BIT_FAS = 14;
  localparam int BIT_SS = 13;
  localparam int BIT_CSV = 12;
  localparam int BIT_CCA = 11;
  localparam int BIT_BCA = 10;
  localparam int BIT_SHDN = 7;
  localparam int BIT_HIB = 6;
  localparam int BIT_DOZE = 5;
  localparam int BIT_SLEEP = 4;
  localparam int BIT_CONSTANT_POWER_MODE = 3;
  localparam int BIT_RUP = 2;
  localparam int BIT_VOK = 1;
  localparam int BIT_QEN = 0;
  // Value written to the update progress location on gauging start.
  localparam logic [7:0] UPDATE_START_VAL = 8'h01;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  // Oscillator start time after deep doze, least figure of the stretch window.
  localparam int CLK_HZ = 10_000_000;
  localparam int WAKE_MS = 6;
  localparam int WAKE_CYCLES_DEF = WAKE_MS * (CLK_HZ / 1000);
  // Power state of the communication oscillator.
  typedef enum logic [1:0] {
    PWR_AWAKE = 2'b00,
    PWR_DEEP_DOZE = 2'b01,
    PWR_WAKING = 2'b10
  } pwr_state_t;
endpackage

// [core/gauge_control_subcommand_unit.sv]
`timescale 1ns/1ps
module gauge_control_subcommand_unit #(
  parameter logic [15:0] DEVICE_TYPE = 16'h1234, // Arbitrary value.
  parameter logic [15:0] FW_REV = 16'h0100, // Arbitrary value.
  parameter logic [15:0] HW_REV = 16'h0001, // Arbitrary value.
  parameter logic [15:0] CHEM_CODE = 16'h0100, // Arbitrary value.
  parameter logic SEALED_AT_RESET = 1'b0,
  parameter logic [15:0] WAKE_CYCLES = 16'(gauge_ctl_pkg::WAKE_CYCLES_DEF)
) (
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire logic LINK_CLK_I,
  input wire logic LINK_WR_I,
  input wire logic LINK_RD_I,
  input wire logic [7:0] LINK_CODE_I,
  input wire logic [7:0] LINK_WDATA_I,
  output logic [7:0] LINK_RDATA_O,
  input wire logic SINGLE_WIRE_I,
  input wire logic SLEEP_I,
  input wire logic HIB_EXIT_I,
  input wire logic SHDN_COND_I,
  input wire logic FULL_ACCESS_SEALED_I,
  input wire logic CCA_I,
  input wire logic BCA_I,
  input wire logic CONSTANT_POWER_MODE_I,
  input wire logic RESISTANCE_UPDATE_DISABLED_I,
  input wire logic VOLT_BAD_I,
  input wire logic [7:0] FULL_RESETS_I,
  input wire logic [7:0] PARTIAL_RESETS_I,
  input wire logic SUM_DONE_I,
  input wire logic [15:0] SUM_VAL_I,
  output logic SUM_REQ_O,
  output logic OSC_OFF_O,
  output logic STRETCH_O,
  output logic HIB_REQ_O,
  output logic SHDN_O,
  output logic SHDN_OE_O,
  output logic GAUGE_START_O,
  output logic UPDATE_WR_O,
  output logic [7:0] UPDATE_DATA_O,
  output logic CAL_MODE_O,
  output logic FULL_RESET_O
);

  // Subcommands that stay usable while sealed.
  function automatic logic sealed_ok(input logic [15:0] sub);
    sealed_ok = (sub == gauge_ctl_pkg::SUB_STATUS) || (sub == gauge_ctl_pkg::SUB_DEV_TYPE) ||
                (sub == gauge_ctl_pkg::SUB_FW_REV) || (sub == gauge_ctl_pkg::SUB_HW_REV) ||
                (sub == gauge_ctl_pkg::SUB_CHEM) || (sub == gauge_ctl_pkg::SUB_DEEP_DOZE) ||
                (sub == gauge_ctl_pkg::SUB_SET_HIB) || (sub == gauge_ctl_pkg::SUB_CLR_HIB) ||
                (sub == gauge_ctl_pkg::SUB_SET_SHDN) || (sub == gauge_ctl_pkg::SUB_CLR_SHDN);
  endfunction

  // A toggle passed through three flops counts once the last two agree and differ from the last seen.
  function automatic logic tgl_event(input logic [2:0] sync, input logic seen);
    tgl_event = (sync[1] == sync[2]) && (sync[2] != seen);
  endfunction

  // ---------------- Link domain ----------------
  logic [7:0] lo_byte_reg;
  logic [15:0] link_cmd_reg;
  logic cmd_tgl_reg;
  logic comm_tgl_reg;
  logic [2:0] ack_sync_reg;
  logic ack_seen_reg;
  logic req_tgl_reg;
  logic [15:0] link_word_reg;
  logic [15:0] hold_reg;
  logic ack_tgl_reg;

  // Low byte is held until the high byte completes the subcommand, then the word is handed over.
  always_ff @(posedge LINK_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      lo_byte_reg <= 8'h00;
      link_cmd_reg <= gauge_ctl_pkg::WORD_ZERO;
      cmd_tgl_reg <= 1'b0;
    end else if (LINK_WR_I && (LINK_CODE_I == gauge_ctl_pkg::CODE_CTL_LO)) begin
      lo_byte_reg <= LINK_WDATA_I;
    end else if (LINK_WR_I && (LINK_CODE_I == gauge_ctl_pkg::CODE_CTL_HI)) begin
      link_cmd_reg <= {LINK_WDATA_I, lo_byte_reg};
      cmd_tgl_reg <= ~cmd_tgl_reg;
    end
  end

  // Every access to any code counts as host communication for the doze logic.
  always_ff @(posedge LINK_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      comm_tgl_reg <= 1'b0;
    end else if (LINK_WR_I || LINK_RD_I) begin
      comm_tgl_reg <= ~comm_tgl_reg;
    end
  end

  // Result word refresh loop: the core offers a snapshot, the link copies it and asks again.
  always_ff @(posedge LINK_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      ack_sync_reg <= 3'b000;
      ack_seen_reg <= 1'b0;
      req_tgl_reg <= 1'b0;
      link_word_reg <= gauge_ctl_pkg::WORD_ZERO;
    end else begin
      ack_sync_reg <= {ack_sync_reg[1:0], ack_tgl_reg};
      if (tgl_event(ack_sync_reg, ack_seen_reg)) begin
        ack_seen_reg <= ack_sync_reg[2];
        link_word_reg <= hold_reg; // Stable while the request is outstanding.
        req_tgl_reg <= ~req_tgl_reg;
      end
    end
  end

  // Read byte is registered; the high code returns the upper half of the word.
  always_ff @(posedge LINK_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      LINK_RDATA_O <= 8'h00;
    end else if (LINK_RD_I) begin
      LINK_RDATA_O <= (LINK_CODE_I == gauge_ctl_pkg::CODE_CTL_HI) ? link_word_reg[15:8] : link_word_reg[7:0];
    end
  end

  // ---------------- Core domain ----------------
  logic [2:0] cmd_sync_reg;
  logic cmd_seen_reg;
  logic [2:0] comm_sync_reg;
  logic comm_seen_reg;
  logic [2:0] req_sync_reg;
  logic req_seen_reg;
  logic cmd_ev;
  logic comm_ev;
  logic [15:0] sub_reg;
  logic [15:0] prev_sub_reg;
  logic exec;
  logic sealed_reg;
  logic doze_bit_reg;
  logic hib_reg;
  logic shdn_en_reg;
  logic se_reg;
  logic csv_reg;
  logic [15:0] sum_reg;
  logic vok_reg;
  logic qen_reg;
  logic cal_reg;
  logic drop_reg;
  logic [15:0] wake_cnt_reg;
  logic [15:0] status;
  logic [15:0] result;
  gauge_ctl_pkg::pwr_state_t pwr_reg;

  assign cmd_ev = tgl_event(cmd_sync_reg, cmd_seen_reg);
  assign comm_ev = tgl_event(comm_sync_reg, comm_seen_reg);

  // Crossings from the link: subcommand arrival, any communication, and refresh requests.
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      cmd_sync_reg <= 3'b000;
      cmd_seen_reg <= 1'b0;
      comm_sync_reg <= 3'b000;
      comm_seen_reg <= 1'b0;
      req_sync_reg <= 3'b000;
      req_seen_reg <= 1'b0;
    end else begin
      cmd_sync_reg <= {cmd_sync_reg[1:0], cmd_tgl_reg};
      comm_sync_reg <= {comm_sync_reg[1:0], comm_tgl_reg};
      req_sync_reg <= {req_sync_reg[1:0], req_tgl_reg};
      if (cmd_ev) begin
        cmd_seen_reg <= cmd_sync_reg[2];
      end
      if (comm_ev) begin
        comm_seen_reg <= comm_sync_reg[2];
      end
      if (tgl_event(req_sync_reg, req_seen_reg)) begin
        req_seen_reg <= req_sync_reg[2];
      end
    end
  end

  // A subcommand runs unless it is dropped on single-wire wake or restricted while sealed.
  assign exec = cmd_ev && !drop_reg && (sealed_ok(link_cmd_reg) || !sealed_reg);

  // The link word is stable here because the host spaces its transfers.
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      sub_reg <= gauge_ctl_pkg::SUB_STATUS;
      prev_sub_reg <= gauge_ctl_pkg::SUB_STATUS;
    end else if (exec) begin
      sub_reg <= link_cmd_reg;
      prev_sub_reg <= sub_reg;
    end
  end

  // Sealing is one way; only reset returns to the strapped state.
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      sealed_reg <= SEALED_AT_RESET;
    end else if (exec && (link_cmd_reg == gauge_ctl_pkg::SUB_SEAL)) begin
      sealed_reg <= 1'b1;
    end
  end

  // Oscillator power state; the stretch holds the first message while the oscillator settles.
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      pwr_reg <= gauge_ctl_pkg::PWR_AWAKE;
      wake_cnt_reg <= 16'h0000;
      drop_reg <= 1'b0;
    end else begin
      unique case (pwr_reg)
        gauge_ctl_pkg::PWR_AWAKE: begin
          if (doze_bit_reg && SLEEP_I && !comm_ev) begin
            pwr_reg <= gauge_ctl_pkg::PWR_DEEP_DOZE;
          end
        end
        gauge_ctl_pkg::PWR_DEEP_DOZE: begin
          if (comm_ev) begin
            pwr_reg <= gauge_ctl_pkg::PWR_WAKING;
            wake_cnt_reg <= WAKE_CYCLES;
            drop_reg <= SINGLE_WIRE_I;
          end
        end
        gauge_ctl_pkg::PWR_WAKING: begin
          if (wake_cnt_reg <= 16'h0001) begin
            pwr_reg <= gauge_ctl_pkg::PWR_AWAKE;
          end
          wake_cnt_reg <= wake_cnt_reg - 16'h0001;
        end
        default: begin
          pwr_reg <= gauge_ctl_pkg::PWR_AWAKE;
        end
      endcase
      if (cmd_ev) begin
        drop_reg <= 1'b0; // Only one message is lost.
      end
    end
  end

  // The set wins: the write that carries the request is itself communication, and would clear it.
  // A later read clears the bit only after its byte was registered from the older snapshot, so that first read can still show it set.
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      doze_bit_reg <= 1'b0;
    end else if (exec && (link_cmd_reg == gauge_ctl_pkg::SUB_DEEP_DOZE)) begin
      doze_bit_reg <= 1'b1;
    end else if (comm_ev) begin
      doze_bit_reg <= 1'b0;
    end
  end

  // Hibernate request; the command set wins over an exit arriving together.
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      hib_reg <= 1'b0;
    end else if (exec && (link_cmd_reg == gauge_ctl_pkg::SUB_SET_HIB)) begin
      hib_reg <= 1'b1;
    end else if (exec && (link_cmd_reg == gauge_ctl_pkg::SUB_CLR_HIB)) begin
      hib_reg <= 1'b0;
    end else if (HIB_EXIT_I) begin
      hib_reg <= 1'b0;
    end
  end

  // Shutdown enable; when disabled the pin floats and the status bit is frozen.
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      shdn_en_reg <= 1'b0;
    end else if (exec && (link_cmd_reg == gauge_ctl_pkg::SUB_SET_SHDN)) begin
      shdn_en_reg <= 1'b1;
    end else if (exec && (link_cmd_reg == gauge_ctl_pkg::SUB_CLR_SHDN)) begin
      shdn_en_reg <= 1'b0;
    end
  end

  // Pin is open drain: driven low only while enabled and the gauge asks for shutdown.
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      se_reg <= 1'b0;
      SHDN_O <= 1'b1;
      SHDN_OE_O <= 1'b0;
    end else begin
      if (shdn_en_reg) begin
        se_reg <= SHDN_COND_I;
        SHDN_OE_O <= SHDN_COND_I;
      end else begin
        SHDN_OE_O <= 1'b0;
      end
      SHDN_O <= 1'b0;
    end
  end

  // Checksum request pulses only unsealed; the last sum stays readable.
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      SUM_REQ_O <= 1'b0;
      sum_reg <= gauge_ctl_pkg::WORD_ZERO;
      csv_reg <= 1'b0;
    end else begin
      SUM_REQ_O <= exec && (link_cmd_reg == gauge_ctl_pkg::SUB_SUM);
      if (SUM_DONE_I) begin
        sum_reg <= SUM_VAL_I;
        csv_reg <= 1'b1;
      end
    end
  end

  // Gauging start: pulses out, sets VOLTAGE_OK_FOR_UPDATE until bad voltage clears it, CAPACITY_UPDATE_ENABLED sticks until reset.
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      GAUGE_START_O <= 1'b0;
      UPDATE_WR_O <= 1'b0;
      UPDATE_DATA_O <= 8'h00;
      vok_reg <= 1'b0;
      qen_reg <= 1'b0;
    end else begin
      GAUGE_START_O <= exec && (link_cmd_reg == gauge_ctl_pkg::SUB_GAUGE_START);
      UPDATE_WR_O <= exec && (link_cmd_reg == gauge_ctl_pkg::SUB_GAUGE_START);
      UPDATE_DATA_O <= gauge_ctl_pkg::UPDATE_START_VAL;
      if (exec && (link_cmd_reg == gauge_ctl_pkg::SUB_GAUGE_START)) begin
        vok_reg <= 1'b1;
        qen_reg <= 1'b1;
      end else if (VOLT_BAD_I) begin
        vok_reg <= 1'b0;
      end
    end
  end

  // Calibration mode latches until reset; full reset is a one-cycle request.
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      cal_reg <= 1'b0;
      FULL_RESET_O <= 1'b0;
    end else begin
      FULL_RESET_O <= exec && (link_cmd_reg == gauge_ctl_pkg::SUB_RESET);
      if (exec && (link_cmd_reg == gauge_ctl_pkg::SUB_CAL_MODE)) begin
        cal_reg <= 1'b1;
      end
    end
  end

  // Live status word; unused bits read zero.
  always_comb begin
    status = gauge_ctl_pkg::WORD_ZERO;
    status[gauge_ctl_pkg::BIT_SE] = se_reg;
    status[gauge_ctl_pkg::BIT_FAS] = FULL_ACCESS_SEALED_I;
    status[gauge_ctl_pkg::BIT_SS] = sealed_reg;
    status[gauge_ctl_pkg::BIT_CSV] = csv_reg;
    status[gauge_ctl_pkg::BIT_CCA] = CCA_I;
    status[gauge_ctl_pkg::BIT_BCA] = BCA_I;
    status[gauge_ctl_pkg::BIT_SHDN] = shdn_en_reg;
    status[gauge_ctl_pkg::BIT_HIB] = hib_reg;
    status[gauge_ctl_pkg::BIT_DOZE] = doze_bit_reg;
    status[gauge_ctl_pkg::BIT_SLEEP] = SLEEP_I;
    status[gauge_ctl_pkg::BIT_CONSTANT_POWER_MODE] = CONSTANT_POWER_MODE_I;
    status[gauge_ctl_pkg::BIT_RUP] = RESISTANCE_UPDATE_DISABLED_I;
    status[gauge_ctl_pkg::BIT_VOK] = vok_reg;
    status[gauge_ctl_pkg::BIT_QEN] = qen_reg;
  end

  // The control word answer is chosen by the last executed subcommand.
  always_comb begin
    unique case (sub_reg)
      gauge_ctl_pkg::SUB_DEV_TYPE: result = DEVICE_TYPE;
      gauge_ctl_pkg::SUB_FW_REV: result = FW_REV;
      gauge_ctl_pkg::SUB_HW_REV: result = HW_REV;
      gauge_ctl_pkg::SUB_SUM: result = sum_reg;
      gauge_ctl_pkg::SUB_RESET_DATA: result = {PARTIAL_RESETS_I, FULL_RESETS_I};
      gauge_ctl_pkg::SUB_LAST: result = prev_sub_reg;
      gauge_ctl_pkg::SUB_CHEM: result = CHEM_CODE;
      default: result = status;
    endcase
  end

  // Snapshot offered to the link; held still until the link asks for the next one.
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      hold_reg <= gauge_ctl_pkg::WORD_ZERO;
      ack_tgl_reg <= 1'b0;
    end else if (ack_tgl_reg == req_seen_reg) begin
      hold_reg <= result;
      ack_tgl_reg <= ~ack_tgl_reg;
    end
  end

  // Power and mode outputs.
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      OSC_OFF_O <= 1'b0;
      STRETCH_O <= 1'b0;
      HIB_REQ_O <= 1'b0;
      CAL_MODE_O <= 1'b0;
    end else begin
      OSC_OFF_O <= (pwr_reg == gauge_ctl_pkg::PWR_DEEP_DOZE) && !comm_ev;
      STRETCH_O <= (pwr_reg == gauge_ctl_pkg::PWR_WAKING) && !SINGLE_WIRE_I;
      HIB_REQ_O <= hib_reg;
      CAL_MODE_O <= cal_reg;
    end
  end

endmodule

// [sim/gauge_ctl_monitor.sv]
`timescale 1ns/1ps
// Watches the core-side outputs of the control unit against their causes.
module gauge_ctl_monitor #(
  parameter logic [15:0] WAKE_CYCLES = 16'h0014
) (
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire logic SINGLE_WIRE_I,
  input wire logic SLEEP_I,
  input wire logic HIB_EXIT_I,
  input wire logic SUM_REQ_O,
  input wire logic OSC_OFF_O,
  input wire logic STRETCH_O,
  input wire logic HIB_REQ_O,
  input wire logic SHDN_O,
  input wire logic SHDN_OE_O,
  input wire logic GAUGE_START_O,
  input wire logic UPDATE_WR_O,
  input wire logic [7:0] UPDATE_DATA_O,
  input wire logic CAL_MODE_O,
  input wire logic FULL_RESET_O
);
  logic [15:0] stretch_cnt;
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!NRST_I);
  // Length of the running stretch, so that a stuck or too short oscillator start shows up.
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      stretch_cnt <= 16'h0000;
    end else begin
      stretch_cnt <= STRETCH_O ? stretch_cnt + 16'h0001 : 16'h0000;
    end
  end
  a_oe_pulls_low: assert property (SHDN_OE_O |-> !SHDN_O)
    else $error("Shutdown pin enabled while not low.");
  a_start_writes_one: assert property (GAUGE_START_O |-> UPDATE_WR_O && UPDATE_DATA_O == 8'h01)
    else $error("Gauging start without progress write.");
  a_start_single: assert property (GAUGE_START_O |=> !GAUGE_START_O)
    else $error("Gauging start longer than one cycle.");
  a_reset_single: assert property (FULL_RESET_O |=> !FULL_RESET_O)
    else $error("Full reset request longer than one cycle.");
  a_cal_holds: assert property (CAL_MODE_O |=> CAL_MODE_O)
    else $error("Calibration mode dropped.");
  a_sum_single: assert property (SUM_REQ_O |=> !SUM_REQ_O)
    else $error("Checksum request longer than one cycle.");
  a_osc_after_sleep: assert property ($rose(OSC_OFF_O) |-> $past(SLEEP_I))
    else $error("Oscillator stopped outside sleep.");
  a_hib_exit_clear: assert property (HIB_EXIT_I |-> ##[1:4] !HIB_REQ_O)
    else $error("Hibernate request kept after exit.");
  a_stretch_wire: assert property (STRETCH_O |-> !SINGLE_WIRE_I)
    else $error("Clock stretch in single-wire mode.");
  a_stretch_bound: assert property (stretch_cnt <= WAKE_CYCLES + 16'h0004)
    else $error("Clock stretch too long.");
  a_stretch_least: assert property ($fell(STRETCH_O) |-> stretch_cnt >= WAKE_CYCLES - 16'h0001)
    else $error("Clock stretch too short.");
  // Main scenarios reached by the bench.
  c_doze: cover property ($rose(OSC_OFF_O));
  c_stretch: cover property ($rose(STRETCH_O));
  c_start: cover property (GAUGE_START_O);
  c_hib_fall: cover property ($fell(HIB_REQ_O));
endmodule

bind gauge_control_subcommand_unit gauge_ctl_monitor #(.WAKE_CYCLES(WAKE_CYCLES)) i_gauge_ctl_monitor (
  .CLK_I(CLK_I), .NRST_I(NRST_I), .SINGLE_WIRE_I(SINGLE_WIRE_I), .SLEEP_I(SLEEP_I), .HIB_EXIT_I(HIB_EXIT_I),
  .SUM_REQ_O(SUM_REQ_O), .OSC_OFF_O(OSC_OFF_O), .STRETCH_O(STRETCH_O), .HIB_REQ_O(HIB_REQ_O), .SHDN_O(SHDN_O),
  .SHDN_OE_O(SHDN_OE_O), .GAUGE_START_O(GAUGE_START_O), .UPDATE_WR_O(UPDATE_WR_O),
  .UPDATE_DATA_O(UPDATE_DATA_O), .CAL_MODE_O(CAL_MODE_O), .FULL_RESET_O(FULL_RESET_O));

// [sim/host_link_model.sv]
`timescale 1ns/1ps
// Host side of the serial link: makes the link clock and moves whole control words.
module host_link_model (
  input wire logic stretch_i,
  input wire logic [7:0] rdata_i,
  output logic link_clk_o,
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] code_o,
  output logic [7:0] wdata_o
);
  logic run = 1'b0;
  // The clock runs only while run is set and halts low while the device stretches it.
  initial begin
    link_clk_o = 1'b0;
    wr_o = 1'b0;
    rd_o = 1'b0;
    code_o = 8'hFF;
    wdata_o = 8'h00;
    forever begin
      #62.5;
      if ((run && !stretch_i) || link_clk_o) link_clk_o = ~link_clk_o;
    end
  end
  // One byte transfer; released lines show the inverse so stale data never looks valid.
  task automatic frame(input logic rd, input logic [7:0] code, input logic [7:0] data);
    @(posedge link_clk_o);
    wr_o <= !rd;
    rd_o <= rd;
    code_o <= code;
    wdata_o <= data;
    @(posedge link_clk_o);
    wr_o <= 1'b0;
    rd_o <= 1'b0;
    code_o <= ~code;
    wdata_o <= ~data;
  endtask
  task automatic idle(input int n);
    run = 1'b1;
    repeat (n) @(posedge link_clk_o);
    run = 1'b0;
  endtask
  // Code byte pair, low then high; the trailing clocks let the result snapshot settle.
  task automatic write_word(input logic [15:0] w);
    run = 1'b1;
    frame(1'b0, gauge_ctl_pkg::CODE_CTL_LO, w[7:0]);
    frame(1'b0, gauge_ctl_pkg::CODE_CTL_HI, w[15:8]);
    idle(20);
  endtask
  task automatic read_word(output logic [15:0] w);
    run = 1'b1;
    frame(1'b1, gauge_ctl_pkg::CODE_CTL_LO, 8'h00);
    @(posedge link_clk_o);
    w[7:0] = rdata_i;
    frame(1'b1, gauge_ctl_pkg::CODE_CTL_HI, 8'h00);
    @(posedge link_clk_o);
    w[15:8] = rdata_i;
    run = 1'b0;
  endtask
endmodule

// [sim/tb_gauge_control_subcommand_unit.sv]
`timescale 1ns/1ps
module tb_gauge_control_subcommand_unit;
  localparam logic [15:0] DEV = 16'h5A5A; // Arbitrary value.
  localparam logic [15:0] FW = 16'h0203;
  localparam logic [15:0] HW = 16'h0004;
  localparam logic [15:0] CHEM = 16'h0311;
  typedef struct {logic [15:0] sub; logic [15:0] exp; bit chk;} row_t;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic sw = 1'b0;
  logic slp = 1'b0;
  logic hibx = 1'b0;
  logic cond = 1'b0;
  logic vbad = 1'b0;
  logic sdone = 1'b0;
  logic [4:0] lvl = 5'b01010;
  logic [4:0] seen = 5'b00000;
  logic [7:0] fres = 8'h2A;
  logic [7:0] pres = 8'h5C;
  logic [15:0] sval = 16'hBEEF;
  logic lclk, lwr, lrd, sumreq, osc, str, hib, shdn, shdn_oe, gst, uwr, cal, frst;
  logic [7:0] lcode, lwd, lrdata, udata;
  logic [15:0] r;
  int errors = 0;
  int total_checks = 0;
  // Table of plain subcommands; status rows follow each action to show its bit.
  row_t rows [14] = '{'{16'h0000, 16'h0808, 1}, '{16'h0001, DEV, 1}, '{16'h0002, FW, 1}, '{16'h0003, HW, 1},
    '{16'h0008, CHEM, 1}, '{16'h0005, 16'h5C2A, 1}, '{16'h0007, 16'h0005, 1}, '{16'h0011, 16'h0000, 0},
    '{16'h0000, 16'h0848, 1}, '{16'h0012, 16'h0000, 0}, '{16'h0000, 16'h0808, 1}, '{16'h0013, 16'h0000, 0},
    '{16'h0000, 16'h0888, 1}, '{16'h0006, 16'h0888, 1}};
  gauge_control_subcommand_unit #(.DEVICE_TYPE(DEV), .FW_REV(FW), .HW_REV(HW), .CHEM_CODE(CHEM),
    .SEALED_AT_RESET(1'b0), .WAKE_CYCLES(16'h0014)) i_gauge_control_subcommand_unit (
    .CLK_I(clk), .NRST_I(nrst), .LINK_CLK_I(lclk), .LINK_WR_I(lwr), .LINK_RD_I(lrd), .LINK_CODE_I(lcode),
    .LINK_WDATA_I(lwd), .LINK_RDATA_O(lrdata), .SINGLE_WIRE_I(sw), .SLEEP_I(slp), .HIB_EXIT_I(hibx),
    .SHDN_COND_I(cond), .FULL_ACCESS_SEALED_I(lvl[4]), .CCA_I(lvl[3]), .BCA_I(lvl[2]), .CONSTANT_POWER_MODE_I(lvl[1]),
    .RESISTANCE_UPDATE_DISABLED_I(lvl[0]), .VOLT_BAD_I(vbad), .FULL_RESETS_I(fres), .PARTIAL_RESETS_I(pres),
    .SUM_DONE_I(sdone), .SUM_VAL_I(sval), .SUM_REQ_O(sumreq), .OSC_OFF_O(osc), .STRETCH_O(str),
    .HIB_REQ_O(hib), .SHDN_O(shdn), .SHDN_OE_O(shdn_oe), .GAUGE_START_O(gst), .UPDATE_WR_O(uwr),
    .UPDATE_DATA_O(udata), .CAL_MODE_O(cal), .FULL_RESET_O(frst));
  host_link_model i_host_link_model (.stretch_i(str), .rdata_i(lrdata), .link_clk_o(lclk), .wr_o(lwr),
    .rd_o(lrd), .code_o(lcode), .wdata_o(lwd));
  initial forever #50 clk = ~clk;
  // Pulses are caught as sticky flags, so a scenario can ask whether one happened at all.
  always @(posedge clk) seen <= seen | {osc, str, frst, gst, sumreq};
  // Checksum engine stand-in answers each request one cycle later.
  always @(posedge clk) sdone <= (sumreq === 1'b1);
  task automatic check(input string name, input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic query(input logic [15:0] w);
    i_host_link_model.write_word(w);
    i_host_link_model.read_word(r);
  endtask
  task automatic clear_seen();
    @(negedge clk) seen = 5'b00000;
  endtask
  task automatic results();
    $display("Checks %0d, mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // The whole sequence needs about 1200 cycles; the limit leaves ample margin.
  initial begin
    repeat (40000) @(posedge clk);
    errors++;
    results();
  end
  initial begin
    fork
      i_host_link_model.idle(12);
      repeat (8) @(posedge clk);
    join
    @(posedge clk) nrst <= 1'b1;
    i_host_link_model.idle(4);
    check("outs", {10'h000, sumreq, osc, str, hib, shdn_oe, cal}, 16'h0000);
    $display("Test reset done");
    foreach (rows[i]) begin
      i_host_link_model.write_word(rows[i].sub);
      if (rows[i].chk) begin
        i_host_link_model.read_word(r);
        check("row word", r, rows[i].exp);
      end
    end
    $display("Test table done");
    // The opposite pattern on the level inputs shows each one lands in its own status bit.
    @(posedge clk) lvl <= 5'b10101;
    query(16'h0000);
    check("levels", r, 16'h4484);
    @(posedge clk) lvl <= 5'b01010;
    @(posedge clk) cond <= 1'b1;
    query(16'h0000);
    check("pin driven", {15'h0000, shdn_oe}, 16'h0001);
    check("status", r, 16'h8888);
    i_host_link_model.write_word(16'h0014);
    @(posedge clk) cond <= 1'b0;
    query(16'h0000);
    check("pin released", {15'h0000, shdn_oe}, 16'h0000);
    check("enable bit", {15'h0000, r[7]}, 16'h0000);
    i_host_link_model.write_word(16'h0011);
    check("hib req", {15'h0000, hib}, 16'h0001);
    @(posedge clk) hibx <= 1'b1;
    @(posedge clk) hibx <= 1'b0;
    repeat (4) @(posedge clk);
    check("hib exit", {15'h0000, hib}, 16'h0000);
    $display("Test shutdown and hibernate done");
    clear_seen();
    query(16'h0004);
    check("sum word", r, 16'hBEEF);
    check("sum req", {15'h0000, seen[0]}, 16'h0001);
    query(16'h0000);
    check("sum valid", {15'h0000, r[12]}, 16'h0001);
    i_host_link_model.write_word(16'h0021);
    check("start", {8'h00, seen[1], udata[6:0]}, 16'h0081);
    query(16'h0000);
    check("update bits", {14'h0000, r[1:0]}, 16'h0003);
    @(posedge clk) vbad <= 1'b1;
    query(16'h0000);
    check("update bits", {14'h0000, r[1:0]}, 16'h0001);
    i_host_link_model.write_word(16'h0040);
    i_host_link_model.write_word(16'h0041);
    check("cal reset", {14'h0000, cal, seen[2]}, 16'h0003);
    $display("Test unsealed actions done");
    i_host_link_model.write_word(16'h0020);
    query(16'h0000);
    check("sealed", {15'h0000, r[13]}, 16'h0001);
    clear_seen();
    i_host_link_model.write_word(16'h0004);
    i_host_link_model.write_word(16'h0041);
    check("refused", {14'h0000, seen[2], seen[0]}, 16'h0000);
    query(16'h0001);
    check("sealed id", r, DEV);
    $display("Test sealed done");
    @(posedge clk) slp <= 1'b1;
    i_host_link_model.write_word(16'h0010);
    check("osc off", {15'h0000, seen[4]}, 16'h0001);
    clear_seen();
    query(16'h0000);
    check("stretch", {15'h0000, seen[3]}, 16'h0001);
    check("doze sleep", {14'h0000, r[5:4]}, 16'h0001);
    $display("Test deep doze done");
    results();
  end
endmodule
